// ==== dv/lpcfg_mem_model.sv ====
/*
 * Memory-side model: makes the memory clock tick and counts the ticks
 * seen since the last refresh command.
 * Assumes one system clock; a divider of zero stops the memory clock.
 */
`timescale 1ns/10ps
module lpcfg_mem_model (
	// clock and reset
	input  wire logic        i_clk_sys,
	input  wire logic        i_reset,
	// tick rate and controller commands
	input  wire logic [3:0]  i_div,
	input  wire logic        i_refresh_cmd,
	// memory side
	output logic             o_mem_tick,
	output logic [15:0]      o_ticks
);
	logic [3:0] cnt_reg;

	//==================================================================
	// memory clock; stands still while the divider is zero
	always_ff @(posedge i_clk_sys) begin
		if (i_reset || i_div == 4'h0) begin
			cnt_reg    <= 4'h0;
			o_mem_tick <= 1'b0;
		end else begin
			o_mem_tick <= (cnt_reg == i_div - 4'h1);
			cnt_reg    <= (cnt_reg >= i_div - 4'h1) ? 4'h0 : cnt_reg + 4'h1;
		end
	end

	//==================================================================
	// ticks since last refresh; a tick in the command cycle is lost
	always_ff @(posedge i_clk_sys) begin
		if (i_reset || i_refresh_cmd) begin
			o_ticks <= 16'h0;
		end else if (o_mem_tick) begin
			o_ticks <= o_ticks + 16'h1;
		end
	end
endmodule

// ==== dv/lpcfg_tb_top.sv ====
/*
 * Self-checking bench of the LPDDR configuration block: register table,
 * pad gating, refresh engine and starvation guard.
 * Assumes the single-cycle register port and the memory-side model.
 */
`timescale 1ns/10ps
module lpcfg_tb_top;
	logic        i_clk_sys, i_reset, i_wr, i_rd, i_txn_done, mem_tick;
	logic [15:0] i_addr, mm_ticks;
	logic [31:0] i_wdata, o_rdata;
	logic [2:0]  i_q_pending, i_q_served, o_q_force, rq_prio;
	logic [3:0]  tick_div;
	logic [13:0] o_load_mode_opcode, phy_ctl, ext_opc;
	lpcfg_pkg::lpcfg_timing_a_t tb_a;
	logic [6:0]  pad_out [4];
	logic        o_refresh_cmd, o_activate_ok;
	int          error_cnt, num_checks, cyc, first, c;
	lpcfg_pkg::lpcfg_timing_b_t tb_b;

	//==================================================================
	// register table: index, reset value, writable bits
	localparam logic [15:0] AT [12] = '{16'hC00A, 16'hC01D, 16'hC01E, 16'hC01F,
		16'hC020, 16'hC021, 16'hD000, 16'hD001, 16'hD002, 16'hD003, 16'hC008, 16'hC0F0};
	localparam logic [31:0] RT [12] = '{32'h4, 32'h2101, 32'h34, 32'h0, 32'h33C30B,
		32'hEE4B, 32'h10, 32'h10, 32'h10, 32'h10, 32'h7, 32'h0};
	localparam logic [31:0] MT [12] = '{32'hF, 32'h3FFF, 32'h3FFF, 32'h3FFF, 32'hFFFFFF,
		32'h3FFFF, 32'h7F, 32'h7F, 32'h7F, 32'h7F, 32'h7, 32'h1};
	localparam int REFI = 6;
	localparam int RFC  = 3;

	lpcfg_top i_lpcfg_top (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_mem_tick(mem_tick), .i_q_pending(i_q_pending), .i_q_served(i_q_served),
		.i_txn_done(i_txn_done), .o_q_force(o_q_force), .o_read_queue_priority(rq_prio),
		.o_phy_control(phy_ctl), .o_load_mode_opcode(o_load_mode_opcode),
		.o_ext_mode_opcode(ext_opc),
		.o_timing_a(tb_a), .o_timing_b(tb_b), .o_refresh_cmd(o_refresh_cmd),
		.o_activate_ok(o_activate_ok), .o_pad_clock(pad_out[0]), .o_pad_cke(pad_out[1]),
		.o_pad_cs(pad_out[2]), .o_pad_we(pad_out[3]));

	lpcfg_mem_model i_lpcfg_mem_model (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
		.i_div(tick_div), .i_refresh_cmd(o_refresh_cmd), .o_mem_tick(mem_tick),
		.o_ticks(mm_ticks));

	initial begin
		i_clk_sys = 1'b0;
		forever #2.5 i_clk_sys = ~i_clk_sys;
	end

	//==================================================================
	// tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic chk_rng(input logic [31:0] v, input int lo, input int hi);
		chk({31'h0, v >= lo && v <= hi}, 32'h1);
	endtask

	task automatic wr_reg(input logic [15:0] a, input logic [31:0] d);
		@(posedge i_clk_sys);
		i_wr    <= 1'b1;
		i_addr  <= a;
		i_wdata <= d;
		@(posedge i_clk_sys);
		i_wr <= 1'b0;
	endtask

	task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp);
		@(posedge i_clk_sys);
		i_rd   <= 1'b1;
		i_addr <= a;
		@(posedge i_clk_sys);
		i_rd <= 1'b0;
		#1 chk(o_rdata, exp);
	endtask

	task automatic do_reset();
		@(posedge i_clk_sys);
		i_reset <= 1'b1;
		repeat (8) @(posedge i_clk_sys);
		i_reset <= 1'b0;
	endtask

	task automatic txn(input logic [2:0] served);
		@(posedge i_clk_sys);
		i_txn_done <= 1'b1;
		i_q_served <= served;
		@(posedge i_clk_sys);
		i_txn_done <= 1'b0;
		i_q_served <= 3'h0;
		@(posedge i_clk_sys);
		#1;
	endtask

	task automatic wait_ref(output int n);
		n = 0;
		do begin
			@(posedge i_clk_sys);
			#1 n++;
		end while (o_refresh_cmd !== 1'b1 && n < 3000);
	endtask

	task automatic end_of_test();
		if (error_cnt == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// run ceiling well above the expected few hundred cycles
	always @(posedge i_clk_sys) begin
		cyc++;
		if (cyc > 30000) begin
			error_cnt++;
			end_of_test();
		end
	end

	//==================================================================
	// main sequence
	initial begin
		{i_wr, i_rd, i_txn_done, i_addr, i_wdata, i_q_served} = '0;
		i_q_pending = 3'h3;
		tick_div    = 4'h0;
		i_reset     = 1'b1;
		repeat (8) @(posedge i_clk_sys);
		i_reset <= 1'b0;
		for (int k = 0; k < 12; k++) rd_chk(AT[k], RT[k]);
		chk(pad_out[0], 7'h0);
		for (int k = 0; k < 12; k++) wr_reg(AT[k], 32'hFFFFFFFF);
		for (int k = 0; k < 12; k++) rd_chk(AT[k], MT[k]);
		chk(o_load_mode_opcode, 14'h3FFF);
		chk(tb_b.small_device_select, 1'b1);
		chk(pad_out[3], 7'h7F);
		chk(rq_prio, 3'h7);
		chk(phy_ctl, 14'h3FFF);
		chk(ext_opc, 14'h3FFF);
		chk(tb_a, 32'h00FFFFFF);
		wr_reg(16'hC008, 32'h0);
		@(posedge i_clk_sys);
		#1 chk(rq_prio, 3'h0);
		wr_reg(16'h1234, 32'hFFFFFFFF);
		rd_chk(16'h1234, 32'h0);
		do_reset();
		for (int k = 0; k < 12; k++) rd_chk(AT[k], RT[k]);
		chk(rq_prio, 3'h7);
		chk(phy_ctl, 14'h2101);
		chk(tb_a, 32'h0033C30B);
		// pads: every drive and pull code, gated by the interface enable
		wr_reg(16'hC0F0, 32'h1);
		@(posedge i_clk_sys);
		#1 chk(pad_out[1], 7'h10);
		for (int k = 0; k < 4; k++) begin
			wr_reg(AT[6 + k], {25'h0, k[0], k[1], k[1:0], k[1:0], k[0]});
			@(posedge i_clk_sys);
			#1 chk(pad_out[k], {k[0], k[1], k[1:0], k[1:0], k[0]});
		end
		wr_reg(16'hC0F0, 32'h0);
		@(posedge i_clk_sys);
		#1 chk(pad_out[2], 7'h0);
		// refresh engine with short counts, prompt and slow memory clock
		wr_reg(16'hC020, 32'h33C000 | REFI);
		wr_reg(16'hC021, 32'h824B | (RFC << 10));
		wr_reg(16'hC0F0, 32'h1);
		for (int d = 1; d <= 4; d += 3) begin
			tick_div <= d[3:0];
			wait_ref(c);
			wait_ref(c);
			chk_rng(mm_ticks, REFI, REFI + RFC + 1);
			chk_rng(c, d * REFI, 2000);
			chk(o_activate_ok, 1'b0);
			c = 0;
			while (o_activate_ok !== 1'b1 && c < 1000) begin
				@(posedge i_clk_sys);
				#1 c++;
			end
			chk_rng(mm_ticks, RFC - 1, RFC + 1);
		end
		wr_reg(16'hC0F0, 32'h0);
		first = 0;
		repeat (100) begin
			@(posedge i_clk_sys);
			#1 if (o_refresh_cmd !== 1'b0 || o_activate_ok !== 1'b0) first = 1;
		end
		chk(first, 0);
		// starvation guard: queue 0 waits while queue 1 is served
		wr_reg(16'hC00A, 32'h3);
		first = 0;
		for (int n = 1; n <= 8; n++) begin
			txn(3'b010);
			if (o_q_force[0] === 1'b1 && first == 0) first = n;
		end
		chk(first, 2);
		chk(o_q_force[2], 1'b0);
		txn(3'b001);
		chk(o_q_force[0], 1'b0);
		wr_reg(16'hC00A, 32'h0);
		first = 0;
		repeat (12) begin
			txn(3'b010);
			if (o_q_force !== 3'h0) first = 1;
		end
		chk(first, 0);
		end_of_test();
	end
endmodule

// ==== include/lpcfg_pkg.sv ====
/*
 * Package of the LPDDR controller configuration block: register indices,
 * field positions, reset values, pad code enumerations and carrier structs.
 * Assumes a plain single-cycle register port and one 200 MHz system clock.
 */
//==================================================================
package lpcfg_pkg;

	//==================================================================
	// register indices (byte address = 4 * index)
	localparam logic [15:0] IDX_ARB_TIMEOUT  = 16'hC00A;
	localparam logic [15:0] IDX_PHY_CONTROL  = 16'hC01D;
	localparam logic [15:0] IDX_LOAD_MODE    = 16'hC01E;
	localparam logic [15:0] IDX_EXT_MODE     = 16'hC01F;
	localparam logic [15:0] IDX_TIMING_FIRST = 16'hC020;
	localparam logic [15:0] IDX_TIMING_SECOND = 16'hC021;
	localparam logic [15:0] IDX_PAD_CLOCK    = 16'hD000;
	localparam logic [15:0] IDX_PAD_CKE      = 16'hD001;
	localparam logic [15:0] IDX_PAD_CS       = 16'hD002;
	localparam logic [15:0] IDX_PAD_WE       = 16'hD003;
	localparam logic [15:0] IDX_READ_PRIO    = 16'hC008;
	localparam logic [15:0] IDX_ENGINE_CTRL  = 16'hC0F0;
	localparam logic [15:0] IDX_ENGINE_STAT  = 16'hC0F1;

	//==================================================================
	// field widths
	localparam int TMO_W   = 4;
	localparam int OPC_W   = 14;
	localparam int PAD_W   = 7;
	localparam int QUEUES  = 3;

	//==================================================================
	// reset values
	localparam logic [3:0]  RST_TIMEOUT   = 4'h4;
	localparam logic [13:0] RST_PHY       = 14'h2101;
	localparam logic [13:0] RST_LOAD_MODE = 14'h0034;
	localparam logic [13:0] RST_EXT_MODE  = 14'h0000;
	localparam logic [2:0]  RST_READ_PRIO = 3'h7;
	localparam logic [10:0] RST_REFI      = 11'h30B;
	localparam logic [3:0]  RST_RAS       = 4'h8;
	localparam logic [5:0]  RST_XSR       = 6'h27;
	localparam logic [2:0]  RST_WR        = 3'h1;
	localparam logic [1:0]  RST_RRD       = 2'h1;
	localparam logic [4:0]  RST_RFC       = 5'h1B;
	localparam logic [2:0]  RST_RP        = 3'h4;
	localparam logic [2:0]  RST_RCD       = 3'h4;
	localparam logic [3:0]  RST_RC        = 4'hB;

	//==================================================================
	// pad codes
	typedef enum logic [1:0] {
		LPCFG_DRV_2MA  = 2'h0,
		LPCFG_DRV_4MA  = 2'h1,
		LPCFG_DRV_8MA  = 2'h2,
		LPCFG_DRV_12MA = 2'h3
	} lpcfg_drive_t;

	typedef enum logic [1:0] {
		LPCFG_PULL_NONE = 2'h0,
		LPCFG_PULL_UP   = 2'h1,
		LPCFG_PULL_DOWN = 2'h2,
		LPCFG_PULL_KEEP = 2'h3
	} lpcfg_pull_t;

	typedef struct packed {
		logic         schmitt;
		logic         slew;
		lpcfg_drive_t drive;
		lpcfg_pull_t  pull;
		logic         receiver;
	} lpcfg_pad_t;

	localparam lpcfg_pad_t RST_PAD = '{1'b0, 1'b0, LPCFG_DRV_8MA, LPCFG_PULL_NONE, 1'b0};
	// pads parked at 2 mA drive with everything else off when the interface is disabled
	localparam lpcfg_pad_t PAD_OFF = '{1'b0, 1'b0, LPCFG_DRV_2MA, LPCFG_PULL_NONE, 1'b0};

	//==================================================================
	// timing word layouts
	typedef struct packed {
		logic [7:0]  rsvd;
		logic [2:0]  write_recovery_count;
		logic [5:0]  self_refresh_exit_count;
		logic [3:0]  active_min_count;
		logic [10:0] refresh_interval_count;
	} lpcfg_timing_a_t;

	typedef struct packed {
		logic [13:0] rsvd;
		logic        small_device_select;
		logic [1:0]  bank_to_bank_count;
		logic [4:0]  refresh_cycle_count;
		logic [2:0]  precharge_count;
		logic [2:0]  row_to_column_count;
		logic [3:0]  row_cycle_count;
	} lpcfg_timing_b_t;

	localparam logic [31:0] MASK_TIMING_A = 32'h00FFFFFF;
	localparam logic [31:0] MASK_TIMING_B = 32'h0003FFFF;

	// engine control bits
	localparam int CTRL_ENABLE = 0;

	//==================================================================
	// refresh engine states, gray along idle-refresh-recover
	typedef enum logic [1:0] {
		LPCFG_ST_IDLE    = 2'b00,
		LPCFG_ST_REFRESH = 2'b01,
		LPCFG_ST_RECOVER = 2'b11
	} lpcfg_state_t;

	// register bus request
	typedef struct packed {
		logic [15:0] addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} lpcfg_bus_t;

endpackage

// ==== logic/lpcfg_starve_guard.sv ====
/*
 * Anti-starvation counter for one arbiter queue.
 * Assumes the arbiter pulses grant events once per transaction.
 */
`timescale 1ns/10ps
module lpcfg_starve_guard (
	// clock and reset
	input  wire logic       i_clk_sys,
	input  wire logic       i_reset,
	// arbiter events
	input  wire logic [3:0] i_limit,
	input  wire logic       i_txn,
	input  wire logic       i_served,
	input  wire logic       i_pending,
	// result
	output logic            o_force
);
	typedef struct packed {
		logic [3:0] waited;
		logic       force_q;
	} lpcfg_guard_t;

	lpcfg_guard_t st_reg;
	lpcfg_guard_t st_next;

	always_comb begin
		st_next = st_reg;
		if (i_served || !i_pending) begin
			st_next.waited = 4'h0;
		end else if (i_txn && st_reg.waited != 4'hF) begin
			st_next.waited = st_reg.waited + 4'h1;
		end
		// limit of zero means no guarantee
		st_next.force_q = (i_limit != 4'h0) && i_pending && !i_served
			&& (st_next.waited >= i_limit - 4'h1);
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign o_force = st_reg.force_q;

endmodule

// ==== logic/lpcfg_top.sv ====
/*
 * LPDDR controller configuration block: register file, pad gating,
 * arbiter starvation guard and a refresh engine in memory clock counts.
 * Assumes a single-cycle register port and a memory clock tick input.
 */
`timescale 1ns/10ps
module lpcfg_top (
	// clock and reset
	input  wire logic                          i_clk_sys,
	input  wire logic                          i_reset,
	// register port
	input  wire logic [15:0]                   i_addr,
	input  wire logic [31:0]                   i_wdata,
	input  wire logic                          i_wr,
	input  wire logic                          i_rd,
	output logic      [31:0]                   o_rdata,
	// memory clock tick and arbiter events
	input  wire logic                          i_mem_tick,
	input  wire logic [lpcfg_pkg::QUEUES-1:0]  i_q_pending,
	input  wire logic [lpcfg_pkg::QUEUES-1:0]  i_q_served,
	input  wire logic                          i_txn_done,
	// arbiter, mode and timing outputs
	output logic [lpcfg_pkg::QUEUES-1:0]       o_q_force,
	output logic [2:0]                         o_read_queue_priority,
	output logic [13:0]                        o_phy_control,
	output logic [13:0]                        o_load_mode_opcode,
	output logic [13:0]                        o_ext_mode_opcode,
	output lpcfg_pkg::lpcfg_timing_a_t         o_timing_a,
	output lpcfg_pkg::lpcfg_timing_b_t         o_timing_b,
	// refresh engine
	output logic                               o_refresh_cmd,
	output logic                               o_activate_ok,
	// pads
	output lpcfg_pkg::lpcfg_pad_t              o_pad_clock,
	output lpcfg_pkg::lpcfg_pad_t              o_pad_cke,
	output lpcfg_pkg::lpcfg_pad_t              o_pad_cs,
	output lpcfg_pkg::lpcfg_pad_t              o_pad_we
);
	//==================================================================
	// state
	typedef struct packed {
		logic [3:0]                  timeout;
		logic [2:0]                  read_prio;
		logic [13:0]                 phy;
		logic [13:0]                 load_mode;
		logic [13:0]                 ext_mode;
		lpcfg_pkg::lpcfg_timing_a_t  tim_a;
		lpcfg_pkg::lpcfg_timing_b_t  tim_b;
		lpcfg_pkg::lpcfg_pad_t       pad_clock;
		lpcfg_pkg::lpcfg_pad_t       pad_cke;
		lpcfg_pkg::lpcfg_pad_t       pad_cs;
		lpcfg_pkg::lpcfg_pad_t       pad_we;
		logic                        enable;
		lpcfg_pkg::lpcfg_state_t     state;
		logic [10:0]                 ref_cnt;
		logic [4:0]                  rfc_cnt;
		logic [31:0]                 rdata;
		logic                        refresh_cmd;
		logic                        activate_ok;
		lpcfg_pkg::lpcfg_pad_t       out_clock;
		lpcfg_pkg::lpcfg_pad_t       out_cke;
		lpcfg_pkg::lpcfg_pad_t       out_cs;
		lpcfg_pkg::lpcfg_pad_t       out_we;
	} lpcfg_top_t;

	lpcfg_top_t st_reg;
	lpcfg_top_t st_next;

	lpcfg_pkg::lpcfg_bus_t bus;
	assign bus = '{i_addr, i_wdata, i_wr, i_rd};

	//==================================================================
	// starvation guard per queue
	genvar g;
	generate
		for (g = 0; g < lpcfg_pkg::QUEUES; g++) begin : gen_guard
			lpcfg_starve_guard u_guard (
				.i_clk_sys (i_clk_sys),
				.i_reset   (i_reset),
				.i_limit   (st_reg.timeout),
				.i_txn     (i_txn_done),
				.i_served  (i_q_served[g]),
				.i_pending (i_q_pending[g]),
				.o_force   (o_q_force[g])
			);
		end
	endgenerate

	//==================================================================
	// next state
	always_comb begin
		st_next = st_reg;
		st_next.refresh_cmd = 1'b0;
		st_next.rdata = 32'h00000000;

		// writes; reserved bits are masked off
		if (bus.wr) begin
			case (bus.addr)
				lpcfg_pkg::IDX_ARB_TIMEOUT: st_next.timeout = bus.wdata[3:0];
				lpcfg_pkg::IDX_READ_PRIO: st_next.read_prio = bus.wdata[2:0];
				lpcfg_pkg::IDX_PHY_CONTROL: st_next.phy = bus.wdata[13:0];
				lpcfg_pkg::IDX_LOAD_MODE: st_next.load_mode = bus.wdata[13:0];
				lpcfg_pkg::IDX_EXT_MODE: st_next.ext_mode = bus.wdata[13:0];
				lpcfg_pkg::IDX_TIMING_FIRST: begin
					st_next.tim_a = bus.wdata & lpcfg_pkg::MASK_TIMING_A;
				end
				lpcfg_pkg::IDX_TIMING_SECOND: begin
					st_next.tim_b = bus.wdata & lpcfg_pkg::MASK_TIMING_B;
				end
				lpcfg_pkg::IDX_PAD_CLOCK: st_next.pad_clock = bus.wdata[6:0];
				lpcfg_pkg::IDX_PAD_CKE: st_next.pad_cke = bus.wdata[6:0];
				lpcfg_pkg::IDX_PAD_CS: st_next.pad_cs = bus.wdata[6:0];
				lpcfg_pkg::IDX_PAD_WE: st_next.pad_we = bus.wdata[6:0];
				lpcfg_pkg::IDX_ENGINE_CTRL: begin
					st_next.enable = bus.wdata[lpcfg_pkg::CTRL_ENABLE];
				end
				default: begin
				end
			endcase
		end

		// reads; unmapped reads return zero
		if (bus.rd) begin
			case (bus.addr)
				lpcfg_pkg::IDX_ARB_TIMEOUT: st_next.rdata = {28'h0000000, st_reg.timeout};
				lpcfg_pkg::IDX_READ_PRIO: st_next.rdata = {29'h00000000, st_reg.read_prio};
				lpcfg_pkg::IDX_PHY_CONTROL: st_next.rdata = {18'h00000, st_reg.phy};
				lpcfg_pkg::IDX_LOAD_MODE: st_next.rdata = {18'h00000, st_reg.load_mode};
				lpcfg_pkg::IDX_EXT_MODE: st_next.rdata = {18'h00000, st_reg.ext_mode};
				lpcfg_pkg::IDX_TIMING_FIRST: st_next.rdata = st_reg.tim_a;
				lpcfg_pkg::IDX_TIMING_SECOND: st_next.rdata = st_reg.tim_b;
				lpcfg_pkg::IDX_PAD_CLOCK: st_next.rdata = {25'h0000000, st_reg.pad_clock};
				lpcfg_pkg::IDX_PAD_CKE: st_next.rdata = {25'h0000000, st_reg.pad_cke};
				lpcfg_pkg::IDX_PAD_CS: st_next.rdata = {25'h0000000, st_reg.pad_cs};
				lpcfg_pkg::IDX_PAD_WE: st_next.rdata = {25'h0000000, st_reg.pad_we};
				lpcfg_pkg::IDX_ENGINE_CTRL: st_next.rdata = {31'h00000000, st_reg.enable};
				lpcfg_pkg::IDX_ENGINE_STAT: begin
					st_next.rdata = {14'h0000, st_reg.rfc_cnt, st_reg.ref_cnt, st_reg.state};
				end
				default: st_next.rdata = 32'h00000000;
			endcase
		end

		// refresh engine; counters advance only on memory clock ticks
		case (st_reg.state)
			lpcfg_pkg::LPCFG_ST_IDLE: begin
				st_next.activate_ok = st_reg.enable;
				if (!st_reg.enable) begin
					st_next.ref_cnt = 11'h000;
				end else if (i_mem_tick) begin
					if (st_reg.ref_cnt + 11'h001 >= st_reg.tim_a.refresh_interval_count) begin
						st_next.ref_cnt = 11'h000;
						st_next.state = lpcfg_pkg::LPCFG_ST_REFRESH;
						st_next.activate_ok = 1'b0;
					end else begin
						st_next.ref_cnt = st_reg.ref_cnt + 11'h001;
					end
				end
			end
			lpcfg_pkg::LPCFG_ST_REFRESH: begin
				st_next.refresh_cmd = 1'b1;
				st_next.activate_ok = 1'b0;
				st_next.rfc_cnt = 5'h00;
				st_next.state = lpcfg_pkg::LPCFG_ST_RECOVER;
			end
			lpcfg_pkg::LPCFG_ST_RECOVER: begin
				st_next.activate_ok = 1'b0;
				if (i_mem_tick) begin
					if (st_reg.rfc_cnt + 5'h01 >= st_reg.tim_b.refresh_cycle_count) begin
						st_next.state = lpcfg_pkg::LPCFG_ST_IDLE;
						st_next.activate_ok = st_reg.enable;
					end else begin
						st_next.rfc_cnt = st_reg.rfc_cnt + 5'h01;
					end
				end
			end
			default: st_next.state = lpcfg_pkg::LPCFG_ST_IDLE;
		endcase

		// pad settings reach the pins only while enabled
		st_next.out_clock = st_next.enable ? st_next.pad_clock : lpcfg_pkg::PAD_OFF;
		st_next.out_cke = st_next.enable ? st_next.pad_cke : lpcfg_pkg::PAD_OFF;
		st_next.out_cs = st_next.enable ? st_next.pad_cs : lpcfg_pkg::PAD_OFF;
		st_next.out_we = st_next.enable ? st_next.pad_we : lpcfg_pkg::PAD_OFF;
	end

	//==================================================================
	// registers
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			st_reg <= '0;
			st_reg.timeout <= lpcfg_pkg::RST_TIMEOUT;
			st_reg.read_prio <= lpcfg_pkg::RST_READ_PRIO;
			st_reg.phy <= lpcfg_pkg::RST_PHY;
			st_reg.load_mode <= lpcfg_pkg::RST_LOAD_MODE;
			st_reg.ext_mode <= lpcfg_pkg::RST_EXT_MODE;
			st_reg.tim_a.write_recovery_count <= lpcfg_pkg::RST_WR;
			st_reg.tim_a.self_refresh_exit_count <= lpcfg_pkg::RST_XSR;
			st_reg.tim_a.active_min_count <= lpcfg_pkg::RST_RAS;
			st_reg.tim_a.refresh_interval_count <= lpcfg_pkg::RST_REFI;
			st_reg.tim_b.small_device_select <= 1'b0;
			st_reg.tim_b.bank_to_bank_count <= lpcfg_pkg::RST_RRD;
			st_reg.tim_b.refresh_cycle_count <= lpcfg_pkg::RST_RFC;
			st_reg.tim_b.precharge_count <= lpcfg_pkg::RST_RP;
			st_reg.tim_b.row_to_column_count <= lpcfg_pkg::RST_RCD;
			st_reg.tim_b.row_cycle_count <= lpcfg_pkg::RST_RC;
			st_reg.pad_clock <= lpcfg_pkg::RST_PAD;
			st_reg.pad_cke <= lpcfg_pkg::RST_PAD;
			st_reg.pad_cs <= lpcfg_pkg::RST_PAD;
			st_reg.pad_we <= lpcfg_pkg::RST_PAD;
			st_reg.out_clock <= lpcfg_pkg::PAD_OFF;
			st_reg.out_cke <= lpcfg_pkg::PAD_OFF;
			st_reg.out_cs <= lpcfg_pkg::PAD_OFF;
			st_reg.out_we <= lpcfg_pkg::PAD_OFF;
			st_reg.state <= lpcfg_pkg::LPCFG_ST_IDLE;
		end else begin
			st_reg <= st_next;
		end
	end

	//==================================================================
	// outputs
	assign o_rdata = st_reg.rdata;
	assign o_read_queue_priority = st_reg.read_prio;
	assign o_phy_control = st_reg.phy;
	assign o_load_mode_opcode = st_reg.load_mode;
	assign o_ext_mode_opcode = st_reg.ext_mode;
	assign o_timing_a = st_reg.tim_a;
	assign o_timing_b = st_reg.tim_b;
	assign o_refresh_cmd = st_reg.refresh_cmd;
	assign o_activate_ok = st_reg.activate_ok;
	assign o_pad_clock = st_reg.out_clock;
	assign o_pad_cke = st_reg.out_cke;
	assign o_pad_cs = st_reg.out_cs;
	assign o_pad_we = st_reg.out_we;

	//==================================================================
	// checks
	sequence s_refresh_issued;
		o_refresh_cmd;
	endsequence

	sequence s_no_activate;
		!o_activate_ok [*2];
	endsequence

	a_timeout_reset: assert property (@(posedge i_clk_sys)
		$fell(i_reset) |-> o_q_force == '0 && st_reg.timeout == lpcfg_pkg::RST_TIMEOUT)
		else $error("timeout not at reset value");

	a_opcode_reset: assert property (@(posedge i_clk_sys)
		$fell(i_reset) |-> o_load_mode_opcode == 14'h0034 && o_ext_mode_opcode == 14'h0000)
		else $error("mode opcodes wrong after reset");

	a_opcode_write: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		i_wr && i_addr == lpcfg_pkg::IDX_EXT_MODE |=> o_ext_mode_opcode == $past(i_wdata[13:0]))
		else $error("extended opcode write lost");

	a_timing_reset: assert property (@(posedge i_clk_sys)
		$fell(i_reset) |-> o_timing_a.refresh_interval_count == 11'h30B
			&& o_timing_b.refresh_cycle_count == 5'h1B && o_timing_b.row_cycle_count == 4'hB)
		else $error("timing reset values wrong");

	a_reserved_zero: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		o_timing_a.rsvd == 8'h00 && o_timing_b.rsvd == 14'h0000)
		else $error("reserved timing bits set");

	a_pad_gated: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		!st_reg.enable |-> o_pad_cs == lpcfg_pkg::PAD_OFF && o_pad_clock == lpcfg_pkg::PAD_OFF)
		else $error("pad setting leaked while disabled");

	a_pad_reset: assert property (@(posedge i_clk_sys)
		$fell(i_reset) |-> st_reg.pad_we == lpcfg_pkg::RST_PAD)
		else $error("pad reset value wrong");

	a_refresh_block: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		s_refresh_issued |-> s_no_activate)
		else $error("activate allowed right after refresh");

	a_refresh_expiry: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		st_reg.state == lpcfg_pkg::LPCFG_ST_REFRESH |=> o_refresh_cmd)
		else $error("refresh not issued after expiry");

	a_small_dev: assert property (@(posedge i_clk_sys)
		$fell(i_reset) |-> !o_timing_b.small_device_select)
		else $error("small device bit set after reset");

	// decode of every mapped index, kept apart from the read mux on purpose
	logic rd_mapped;
	assign rd_mapped = i_addr inside {lpcfg_pkg::IDX_ARB_TIMEOUT, lpcfg_pkg::IDX_PHY_CONTROL,
		lpcfg_pkg::IDX_LOAD_MODE, lpcfg_pkg::IDX_EXT_MODE, lpcfg_pkg::IDX_TIMING_FIRST,
		lpcfg_pkg::IDX_TIMING_SECOND, lpcfg_pkg::IDX_PAD_CLOCK, lpcfg_pkg::IDX_PAD_CKE,
		lpcfg_pkg::IDX_PAD_CS, lpcfg_pkg::IDX_PAD_WE, lpcfg_pkg::IDX_READ_PRIO,
		lpcfg_pkg::IDX_ENGINE_CTRL, lpcfg_pkg::IDX_ENGINE_STAT};

	a_unmapped_read: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		i_rd && !rd_mapped |=> o_rdata == 32'h00000000)
		else $error("unmapped read returned data");

	a_timeout_write: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		i_wr && i_addr == lpcfg_pkg::IDX_ARB_TIMEOUT |=> st_reg.timeout == $past(i_wdata[3:0]))
		else $error("timeout write lost");

	a_timing_write: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		i_wr && i_addr == lpcfg_pkg::IDX_TIMING_SECOND
			|=> o_timing_b == ($past(i_wdata) & lpcfg_pkg::MASK_TIMING_B))
		else $error("second timing word write wrong");

	a_prio_reset: assert property (@(posedge i_clk_sys)
		$fell(i_reset) |-> o_read_queue_priority == lpcfg_pkg::RST_READ_PRIO)
		else $error("read queue priority wrong after reset");

	a_force_off: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		st_reg.timeout == 4'h0 |=> o_q_force == '0)
		else $error("force raised with timeout disabled");

	a_force_served: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		i_q_served != '0 |=> (o_q_force & $past(i_q_served)) == '0)
		else $error("force kept on a served queue");

	a_refresh_pulse: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		o_refresh_cmd |=> !o_refresh_cmd)
		else $error("refresh command longer than one cycle");

	a_recover_hold: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		st_reg.state == lpcfg_pkg::LPCFG_ST_RECOVER && !i_mem_tick
			|=> st_reg.state == lpcfg_pkg::LPCFG_ST_RECOVER)
		else $error("recovery advanced without memory tick");

	a_idle_hold: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		st_reg.state == lpcfg_pkg::LPCFG_ST_IDLE && !i_mem_tick
			|=> st_reg.state == lpcfg_pkg::LPCFG_ST_IDLE)
		else $error("refresh started without memory tick");

	a_pad_follow: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		st_reg.enable |-> o_pad_we == st_reg.pad_we && o_pad_cke == st_reg.pad_cke
			&& o_pad_clock == st_reg.pad_clock)
		else $error("pad output differs from its register");

	a_activate_off: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		!st_reg.enable && st_reg.state == lpcfg_pkg::LPCFG_ST_IDLE |=> !o_activate_ok)
		else $error("activate allowed while disabled");

	a_pad_reset_all: assert property (@(posedge i_clk_sys)
		$fell(i_reset) |-> st_reg.pad_clock == lpcfg_pkg::RST_PAD
			&& st_reg.pad_cke == lpcfg_pkg::RST_PAD && st_reg.pad_cs == lpcfg_pkg::RST_PAD)
		else $error("pad registers wrong after reset");

endmodule
